// ===== src/rnsc_pkg.sv
// Package of constants and types for the reset, NMI and SMM pin control block.
package rnsc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned RNSC_CPU_RESET_CYCLES = 64;
    localparam logic [6:0] RNSC_RESET_LAST = 7'(RNSC_CPU_RESET_CYCLES - 1);

    // ------------------------------------------------------------------
    // Decodes and field positions
    // ------------------------------------------------------------------
    localparam logic [15:0] RNSC_KBC_CMD_PORT = 16'h0064;
    localparam logic [7:0] RNSC_KBC_RESET_CMD = 8'hFE;
    localparam int unsigned RNSC_PORT61_SPK_BIT = 1;
    localparam int unsigned RNSC_SMM_IGNORE_BIT = 7;
    localparam int unsigned RNSC_KBRST_NOW_BIT = 1;

    // Bus cycle definition code {m_io, d_c, w_r} and byte-enable codes for special cycles.
    localparam logic [2:0] RNSC_CYC_SPECIAL = 3'h1;
    localparam logic [1:0] RNSC_BE_SHUTDOWN = 2'h0;
    localparam logic [1:0] RNSC_BE_HALT = 2'h2;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic RNSC_STRAP_RST = 1'b0;

    typedef enum logic [1:0] {
        RNSC_IDLE,
        RNSC_WAIT_HALT,
        RNSC_PULSE
    } rnsc_rst_state_t;

endpackage

// ===== src/rnsc_sync3.sv
// Three-stage synchroniser with agreement filter for one pin input.
`timescale 1ns/1ns
module rnsc_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Pin and filtered level
    input wire logic pin_i,
    output logic level_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // --------------------------------------------------------------
    // Sampling chain
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            level_o <= RST_VAL;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // A change counts only once the second and third stages agree.
            if (s2_reg == s3_reg) begin
                level_o <= s3_reg;
            end
        end
    end
endmodule

// ===== src/rnsc_top.sv
// Reset, NMI, speaker and SMM pin control of the system controller.
`timescale 1ns/1ns
module rnsc_top (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Power and CPU reset
    input wire logic power_good_in_i,
    output logic cpu_reset_out_o,
    // CPU bus cycle decode
    input wire logic cpu_ads_n_i,
    input wire logic cpu_m_io_i,
    input wire logic cpu_d_c_i,
    input wire logic cpu_w_r_i,
    input wire logic [3:0] cpu_be_n_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_write_strobe_i,
    // NMI sources
    input wire logic nmi_enable_i,
    input wire logic channel_check_n_i,
    input wire logic parity_error_i,
    output logic nmi_o,
    // Speaker
    input wire logic timer2_output_i,
    input wire logic [7:0] port61_i,
    output logic speaker_out_o,
    // Dual-use pin
    input wire logic pin_function_strap_i,
    input wire logic dual_pin_i,
    input wire logic dram_to_cpu_i,
    output logic dual_pin_o,
    output logic dual_pin_oe_o,
    // SMM control
    input wire logic [7:0] cfg_e7_i,
    input wire logic [7:0] cfg_20_i,
    input wire logic ext_int_selects_smi_i,
    input wire logic smm_style_alt_i,
    input wire logic cpu_low_power_i,
    input wire logic green_req_i,
    input wire logic normal_req_i,
    input wire logic smm_active_n_i,
    output logic smm_access_ok_o,
    output logic smi_power_port_n_o
);
    import rnsc_pkg::*;

    logic pg_level;
    logic channel_check_n_level;
    logic smm_level;
    logic ext_level;
    logic strap_reg;
    logic strap_taken_reg;
    logic ext_prev_reg;
    logic smm_prev_reg;
    logic smm_open_reg;
    logic [6:0] rst_cnt_reg;
    rnsc_rst_state_t state_reg;
    logic shutdown_cyc;
    logic halt_cyc;
    logic kbc_reset;
    logic ext_fall;
    logic smi_pulse;
    logic power_port_enable_n_pulse;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    rnsc_sync3 #(.RST_VAL(1'b0)) u_pg (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(power_good_in_i),
        .level_o(pg_level)
    );
    rnsc_sync3 #(.RST_VAL(1'b1)) u_channel_check_n (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(channel_check_n_i),
        .level_o(channel_check_n_level)
    );
    rnsc_sync3 #(.RST_VAL(1'b1)) u_smm (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(smm_active_n_i),
        .level_o(smm_level)
    );
    rnsc_sync3 #(.RST_VAL(1'b1)) u_ext (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(dual_pin_i),
        .level_o(ext_level)
    );

    // ------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------
    function automatic logic special_cycle(input logic [1:0] code);
        special_cycle = !cpu_ads_n_i
            && ({cpu_m_io_i, cpu_d_c_i, cpu_w_r_i} == RNSC_CYC_SPECIAL)
            && (cpu_be_n_i[1:0] == code);
    endfunction

    always_comb begin
        shutdown_cyc = special_cycle(RNSC_BE_SHUTDOWN);
        halt_cyc = special_cycle(RNSC_BE_HALT);
        kbc_reset = io_write_strobe_i && (io_addr_i == RNSC_KBC_CMD_PORT)
            && (io_wdata_i == RNSC_KBC_RESET_CMD);
    end

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // The strap is caught while the system is held in power-good reset,
    // so a clocked capture is used rather than the asynchronous reset.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            strap_reg <= RNSC_STRAP_RST;
            strap_taken_reg <= 1'b0;
        end else begin
            if (!strap_taken_reg || !pg_level) begin
                strap_reg <= pin_function_strap_i;
            end
            strap_taken_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // CPU reset generator
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= RNSC_PULSE;
            rst_cnt_reg <= 7'h00;
        end else begin
            case (state_reg)
                RNSC_IDLE: begin
                    rst_cnt_reg <= 7'h00;
                    if (!pg_level || shutdown_cyc) begin
                        state_reg <= RNSC_PULSE;
                    end else if (kbc_reset) begin
                        if (cfg_20_i[RNSC_KBRST_NOW_BIT]) begin
                            state_reg <= RNSC_PULSE;
                        end else begin
                            state_reg <= RNSC_WAIT_HALT;
                        end
                    end
                end
                RNSC_WAIT_HALT: begin
                    if (!pg_level || shutdown_cyc || halt_cyc) begin
                        state_reg <= RNSC_PULSE;
                    end
                end
                RNSC_PULSE: begin
                    // Power-good low clears the count, so the pulse runs its
                    // full length after power returns.
                    if (!pg_level) begin
                        rst_cnt_reg <= 7'h00;
                    end else if (rst_cnt_reg == RNSC_RESET_LAST) begin
                        state_reg <= RNSC_IDLE;
                    end else begin
                        rst_cnt_reg <= rst_cnt_reg + 7'h01;
                    end
                end
                default: begin
                    state_reg <= RNSC_PULSE;
                end
            endcase
        end
    end

    assign cpu_reset_out_o = (state_reg == RNSC_PULSE);

    // ------------------------------------------------------------------
    // NMI and speaker
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            nmi_o <= 1'b0;
        end else begin
            nmi_o <= nmi_enable_i
                && (!channel_check_n_level || parity_error_i);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            speaker_out_o <= 1'b0;
        end else begin
            speaker_out_o <= timer2_output_i
                && port61_i[RNSC_PORT61_SPK_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Dual-use pin
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dual_pin_o <= 1'b1;
            dual_pin_oe_o <= 1'b0;
        end else begin
            dual_pin_oe_o <= !strap_reg;
            dual_pin_o <= !dram_to_cpu_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ext_prev_reg <= 1'b1;
        end else begin
            ext_prev_reg <= ext_level;
        end
    end

    assign ext_fall = strap_reg && ext_prev_reg && !ext_level;

    // ------------------------------------------------------------------
    // SMI and power-port strobe
    // ------------------------------------------------------------------
    // Only a low-power CPU in SMI style gets SMI; in the other style its green request
    // gives no strobe, and every other request becomes the power-port strobe to the companion port.
    always_comb begin
        smi_pulse = cpu_low_power_i && !smm_style_alt_i
            && (green_req_i
                || (ext_fall && ext_int_selects_smi_i));
        power_port_enable_n_pulse = normal_req_i || !cpu_low_power_i && green_req_i
            || (ext_fall && !smi_pulse);
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            smi_power_port_n_o <= 1'b1;
        end else begin
            smi_power_port_n_o <= !(smi_pulse || power_port_enable_n_pulse);
        end
    end

    // ------------------------------------------------------------------
    // SMM access qualification
    // ------------------------------------------------------------------
    // In strobe style the window opens on a strobe and closes at the next
    // CPU address strobe that is not itself a strobe of the SMM kind.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            smm_prev_reg <= 1'b1;
            smm_open_reg <= 1'b0;
        end else begin
            smm_prev_reg <= smm_level;
            if (smm_prev_reg && !smm_level) begin
                smm_open_reg <= 1'b1;
            end else if (!cpu_ads_n_i && smm_level) begin
                smm_open_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            smm_access_ok_o <= 1'b0;
        end else if (cfg_e7_i[RNSC_SMM_IGNORE_BIT]) begin
            smm_access_ok_o <= 1'b1;
        end else if (smm_style_alt_i) begin
            smm_access_ok_o <= smm_open_reg;
        end else begin
            smm_access_ok_o <= !smm_level;
        end
    end
endmodule

// ===== tb/rnsc_assertions.sv
// Concurrent checks on the ports of the reset, NMI and SMM pin block.
`timescale 1ns/1ns
module rnsc_assertions (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Reset sources and CPU reset
    input wire logic power_good_in_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_write_strobe_i,
    input wire logic [7:0] cfg_20_i,
    input wire logic cpu_reset_out_o,
    // NMI and SMM
    input wire logic nmi_enable_i,
    input wire logic parity_error_i,
    input wire logic nmi_o,
    input wire logic [7:0] cfg_e7_i,
    input wire logic smm_access_ok_o,
    input wire logic smi_power_port_n_o
);
    import rnsc_pkg::*;
    logic [7:0] run_reg;
    logic [3:0] pg_hist_reg;
    logic dirty_reg;
    logic kb_hit;
    assign kb_hit = io_write_strobe_i && !cpu_reset_out_o
        && io_addr_i == RNSC_KBC_CMD_PORT && io_wdata_i == RNSC_KBC_RESET_CMD;
    // A pulse that power-good held open is longer on purpose, so any
    // recent low power-good marks the pulse as not measurable.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            run_reg <= 8'h00;
            pg_hist_reg <= 4'h0;
            dirty_reg <= 1'b1;
        end else begin
            pg_hist_reg <= {pg_hist_reg[2:0], power_good_in_i};
            run_reg <= cpu_reset_out_o ? run_reg + 8'h01 : 8'h00;
            if (!(&pg_hist_reg) || !power_good_in_i) begin
                dirty_reg <= 1'b1;
            end else if (!cpu_reset_out_o) begin
                dirty_reg <= 1'b0;
            end
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_nmi_parity: assert property (
        nmi_enable_i && parity_error_i |=> nmi_o)
        else $error("nmi missing after parity error");
    a_nmi_mask: assert property (
        !nmi_enable_i |=> !nmi_o)
        else $error("nmi raised while disabled");
    a_reset_len: assert property (
        $fell(cpu_reset_out_o) && !dirty_reg |-> run_reg == 8'h40)
        else $error("cpu reset pulse length wrong");
    a_pg_reset: assert property (
        !power_good_in_i [*3] |-> ##[1:6] cpu_reset_out_o)
        else $error("no cpu reset on power-good low");
    a_kb_fast: assert property (
        kb_hit && cfg_20_i[RNSC_KBRST_NOW_BIT] |=> cpu_reset_out_o)
        else $error("keyboard reset not immediate");
    a_kb_defer: assert property (
        kb_hit && !cfg_20_i[RNSC_KBRST_NOW_BIT] |=> !cpu_reset_out_o)
        else $error("keyboard reset did not wait for halt");
    a_smm_ignore: assert property (
        cfg_e7_i[RNSC_SMM_IGNORE_BIT] |=> smm_access_ok_o)
        else $error("smm access refused while input ignored");
    a_strobe_one: assert property (
        !smi_power_port_n_o |=> smi_power_port_n_o)
        else $error("strobe longer than one cycle");
endmodule

bind rnsc_top rnsc_assertions rnsc_assertions_inst (.*);

// ===== tb/rnsc_far_model.sv
// Far-side model: CPU bus cycle source and companion reset generator.
`timescale 1ns/1ns
module rnsc_far_model (
    // Clock and power
    input wire logic clk_sys_i,
    input wire logic power_good_in_i,
    // Cycle request from the bench
    input wire logic cyc_go_i,
    input wire logic [1:0] cyc_code_i,
    // CPU bus and companion reset
    output logic cpu_ads_n_o,
    output logic [2:0] cpu_def_o,
    output logic [3:0] cpu_be_n_o,
    output logic isa_reset_drive_o
);
    import rnsc_pkg::*;
    logic [6:0] pg_count_reg;
    initial begin
        cpu_ads_n_o = 1'b1;
        cpu_def_o = 3'h0;
        cpu_be_n_o = 4'hF;
        pg_count_reg = 7'h00;
    end
    // Outside a cycle the definition lines hold the special code and the
    // byte enables step through every code, shutdown and halt included,
    // so a decoder that ignores the strobe misfires.
    always @(posedge clk_sys_i) begin
        cpu_ads_n_o <= !cyc_go_i;
        cpu_def_o <= RNSC_CYC_SPECIAL;
        cpu_be_n_o <= cyc_go_i ? {2'h3, cyc_code_i} : cpu_be_n_o + 4'h1;
    end
    always @(posedge clk_sys_i) begin
        if (!power_good_in_i) begin
            pg_count_reg <= 7'h00;
        end else if (pg_count_reg != 7'h40) begin
            pg_count_reg <= pg_count_reg + 7'h01;
        end
    end
    assign isa_reset_drive_o = pg_count_reg != 7'h40;
endmodule

// ===== tb/rnsc_tb_top.sv
// Self-checking bench for the reset, NMI and SMM pin control block.
`timescale 1ns/1ns
module rnsc_tb_top;
    import rnsc_pkg::*;
    logic clk_sys_i, rst_i, power_good_in_i, cpu_reset_out_o, cpu_ads_n_i;
    logic cpu_m_io_i, cpu_d_c_i, cpu_w_r_i, io_write_strobe_i, nmi_enable_i;
    logic channel_check_n_i, parity_error_i, nmi_o, timer2_output_i;
    logic speaker_out_o, pin_function_strap_i, dual_pin_i, dram_to_cpu_i;
    logic dual_pin_o, dual_pin_oe_o, ext_int_selects_smi_i, smm_style_alt_i;
    logic cpu_low_power_i, green_req_i, normal_req_i, smm_active_n_i;
    logic smm_access_ok_o, smi_power_port_n_o, cyc_go, isa_rst;
    logic [1:0] cyc_code;
    logic [3:0] cpu_be_n_i;
    logic [15:0] io_addr_i;
    logic [7:0] io_wdata_i, port61_i, cfg_e7_i, cfg_20_i;
    int fail_count, samples_checked, n;

    rnsc_top rnsc_top_inst (.*);
    rnsc_far_model rnsc_far_model_inst (
        .clk_sys_i(clk_sys_i),
        .power_good_in_i(power_good_in_i),
        .cyc_go_i(cyc_go),
        .cyc_code_i(cyc_code),
        .cpu_ads_n_o(cpu_ads_n_i),
        .cpu_def_o({cpu_m_io_i, cpu_d_c_i, cpu_w_r_i}),
        .cpu_be_n_o(cpu_be_n_i),
        .isa_reset_drive_o(isa_rst)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task print_verdict();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task tick(input int c);
        repeat (c) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v) begin
            if (n == lim) begin
                chk("bounded wait", 8'(v), 8'(s));
                print_verdict();
            end
            tick(1);
            n++;
        end
    endtask
    task kb_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_write_strobe_i <= 1'b1;
        @(posedge clk_sys_i);
        io_write_strobe_i <= 1'b0;
        #1;
    endtask
    task bus_cycle(input logic [1:0] code);
        @(posedge clk_sys_i);
        cyc_go <= 1'b1;
        cyc_code <= code;
        @(posedge clk_sys_i);
        cyc_go <= 1'b0;
        #1;
    endtask

    task t_pin_and_speaker();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_i);
            dram_to_cpu_i <= i[0];
            timer2_output_i <= i[0];
            port61_i <= i[1] ? 8'h02 : 8'hFD;
            tick(2);
            chk("dir oe", 8'h01, 8'(dual_pin_oe_o));
            chk("dir level", 8'(!i[0]), 8'(dual_pin_o));
            chk("speaker", 8'(i[0] & i[1]), 8'(speaker_out_o));
        end
    endtask
    task t_nmi();
        @(posedge clk_sys_i);
        nmi_enable_i <= 1'b1;
        parity_error_i <= 1'b1;
        tick(2);
        chk("nmi parity", 8'h01, 8'(nmi_o));
        @(posedge clk_sys_i);
        parity_error_i <= 1'b0;
        channel_check_n_i <= 1'b0;
        tick(6);
        chk("nmi channel_check_n", 8'h01, 8'(nmi_o));
        @(posedge clk_sys_i);
        nmi_enable_i <= 1'b0;
        tick(2);
        chk("nmi masked", 8'h00, 8'(nmi_o));
        channel_check_n_i <= 1'b1;
    endtask
    task t_keyboard();
        kb_write(16'h0060, RNSC_KBC_RESET_CMD);
        kb_write(RNSC_KBC_CMD_PORT, 8'hFD);
        tick(2);
        chk("kb other", 8'h00, 8'(cpu_reset_out_o));
        kb_write(RNSC_KBC_CMD_PORT, RNSC_KBC_RESET_CMD);
        chk("kb fast", 8'h01, 8'(cpu_reset_out_o));
        wait_for(cpu_reset_out_o, 1'b0, 80);
        chk("kb len", 8'h40, 8'(n));
        cfg_20_i <= 8'h00;
        kb_write(RNSC_KBC_CMD_PORT, RNSC_KBC_RESET_CMD);
        tick(8);
        chk("kb wait", 8'h00, 8'(cpu_reset_out_o));
        bus_cycle(RNSC_BE_HALT);
        wait_for(cpu_reset_out_o, 1'b1, 3);
        wait_for(cpu_reset_out_o, 1'b0, 80);
        chk("halt len", 8'h40, 8'(n));
    endtask
    task t_shutdown_power();
        bus_cycle(RNSC_BE_SHUTDOWN);
        wait_for(cpu_reset_out_o, 1'b1, 3);
        wait_for(cpu_reset_out_o, 1'b0, 80);
        chk("shutdown len", 8'h40, 8'(n));
        power_good_in_i <= 1'b0;
        pin_function_strap_i <= 1'b1;
        wait_for(cpu_reset_out_o, 1'b1, 8);
        tick(4);
        chk("strap oe", 8'h00, 8'(dual_pin_oe_o));
        chk("isa reset held", 8'h01, 8'(isa_rst));
        power_good_in_i <= 1'b1;
        wait_for(cpu_reset_out_o, 1'b0, 80);
        chk("isa reset end", 8'h00, 8'(isa_rst));
    endtask
    task t_strobes();
        // Green entry, return, then green on a CPU without SMI support.
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys_i);
            cpu_low_power_i <= (i != 2);
            green_req_i <= (i != 1);
            normal_req_i <= (i == 1);
            @(posedge clk_sys_i);
            green_req_i <= 1'b0;
            normal_req_i <= 1'b0;
            #1;
            chk("pin strobe", 8'h00, 8'(smi_power_port_n_o));
            tick(1);
            chk("strobe end", 8'h01, 8'(smi_power_port_n_o));
        end
        @(posedge clk_sys_i);
        dual_pin_i <= 1'b0;
        wait_for(smi_power_port_n_o, 1'b0, 10);
        dual_pin_i <= 1'b1;
    endtask
    task t_smm();
        cfg_e7_i <= 8'h80;
        tick(2);
        chk("smm ignore", 8'h01, 8'(smm_access_ok_o));
        cfg_e7_i <= 8'h00;
        smm_active_n_i <= 1'b0;
        tick(6);
        chk("smm ack", 8'h01, 8'(smm_access_ok_o));
        smm_active_n_i <= 1'b1;
        tick(6);
        chk("smm idle", 8'h00, 8'(smm_access_ok_o));
        // An ordinary address strobe closes any window left open earlier.
        smm_style_alt_i <= 1'b1;
        bus_cycle(2'h3);
        tick(2);
        chk("smm closed", 8'h00, 8'(smm_access_ok_o));
        smm_active_n_i <= 1'b0;
        tick(6);
        chk("smm strobe", 8'h01, 8'(smm_access_ok_o));
        smm_active_n_i <= 1'b1;
        tick(6);
        chk("smm held", 8'h01, 8'(smm_access_ok_o));
        bus_cycle(2'h3);
        tick(2);
        chk("smm shut", 8'h00, 8'(smm_access_ok_o));
    endtask

    initial begin
        {power_good_in_i, channel_check_n_i, dual_pin_i, smm_active_n_i} = 4'hF;
        {io_write_strobe_i, nmi_enable_i, parity_error_i, timer2_output_i} = 4'h0;
        {pin_function_strap_i, dram_to_cpu_i, smm_style_alt_i} = 3'h0;
        {cpu_low_power_i, green_req_i, normal_req_i, cyc_go} = 4'h0;
        {io_addr_i, io_wdata_i, port61_i, cfg_e7_i} = 40'h0;
        ext_int_selects_smi_i = 1'b1;
        cyc_code = 2'h3;
        cfg_20_i = 8'h02;
        rst_i = 1'b1;
        fail_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        wait_for(cpu_reset_out_o, 1'b0, 100);
        t_pin_and_speaker();
        t_nmi();
        t_keyboard();
        t_shutdown_power();
        t_strobes();
        t_smm();
        print_verdict();
    end
endmodule
